/* File: hw/gpw_pkg.sv */
// Constants for the pin wakeup and external interrupt block
package gpw_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [31:0] ADDR_PENDING = 32'h4000a814;
    localparam logic [31:0] ADDR_CFG_A = 32'h4000a860;
    localparam logic [31:0] ADDR_CFG_B = 32'h4000a864;
    localparam logic [31:0] ADDR_CFG_C = 32'h4000a868;
    localparam logic [31:0] ADDR_CFG_D = 32'h4000a86c;
    localparam logic [31:0] ADDR_WAKE_A = 32'h4000bc08;
    localparam logic [31:0] ADDR_WAKE_B = 32'h4000bc0c;
    localparam logic [31:0] ADDR_WAKE_C = 32'h4000bc10;
    localparam logic [31:0] ADDR_SEL_C = 32'h4000bc14;
    localparam logic [31:0] ADDR_SEL_D = 32'h4000bc18;
    localparam logic [31:0] ADDR_WAKE_FILT = 32'h4000bc1c;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000bc20;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_FILT_BIT = 8;
    localparam int CFG_MODE_LSB = 5;
    localparam int WFILT_PINS_BIT = 0;
    localparam int WFILT_SER1_BIT = 1;
    localparam int WFILT_SER2_BIT = 2;
    localparam int WFILT_EXTD_BIT = 3;
    localparam int SER1_WAKE_PIN = 10;
    localparam int SER2_WAKE_PIN = 2;
    localparam int EXT_A_LINE = 24;
    localparam int EXT_B_LINE = 25;
    localparam logic [4:0] SEL_LAST_PIN = 5'h17;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [4:0] SEL_C_RESET = 5'h0f;
    localparam logic [4:0] SEL_D_RESET = 5'h10;
    // ****************************************
    // Trigger modes
    // ****************************************
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_RISE = 3'h1;
    localparam logic [2:0] MODE_FALL = 3'h2;
    localparam logic [2:0] MODE_BOTH = 3'h3;
    localparam logic [2:0] MODE_HIGH = 3'h4;
    localparam logic [2:0] MODE_LOW = 3'h5;
    // ****************************************
    // Timing
    // ****************************************
    localparam int FILTER_CYCLES = 4;
endpackage

/* File: hw/gpw_trig_detect.sv */
// Edge and level trigger detector for one external interrupt line
`timescale 1ns/1ps
module gpw_trig_detect
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Line and mode
    input wire logic level,
    input wire logic [2:0] mode,
    // Result
    output logic trigEvent
);
    typedef struct packed
    {
        logic prev;
    } gpw_trig_state_type;

    gpw_trig_state_type st;
    gpw_trig_state_type next_st;

    always_comb
    begin
        next_st.prev = level;
        case (mode)
            gpw_pkg::MODE_RISE: trigEvent = level & ~st.prev;
            gpw_pkg::MODE_FALL: trigEvent = ~level & st.prev;
            gpw_pkg::MODE_BOTH: trigEvent = level ^ st.prev;
            gpw_pkg::MODE_HIGH: trigEvent = level;
            gpw_pkg::MODE_LOW: trigEvent = ~level;
            // Off and the two spare codes never fire
            default: trigEvent = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    a_rise_edge_only: assert property (@(posedge clk) disable iff (!resetn)
        (mode == gpw_pkg::MODE_RISE && trigEvent) |-> level && !$past(level))
        else $error("rising mode fired without a rising edge");
endmodule

/* File: hw/gpw_wake_irq.sv */
// Pin wakeup monitor and external interrupt controller with Avalon-MM registers
`timescale 1ns/1ps
module gpw_wake_irq
#(
    parameter int FILTER_CYCLES = gpw_pkg::FILTER_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Port pins and dedicated interrupt pins
    input wire logic [7:0] portA,
    input wire logic [7:0] portB,
    input wire logic [7:0] portC,
    input wire logic extIntA,
    input wire logic extIntB,
    // Events out
    output logic irq,
    output logic wakeEvent
);
    localparam int CW = $clog2(FILTER_CYCLES + 1);
    localparam logic [CW-1:0] FILT_LAST = CW'(FILTER_CYCLES - 1);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        logic [25:0] sync1;
        logic [25:0] sync2;
        logic [25:0] filt;
        logic [25:0][CW-1:0] filtCnt;
        logic [24:0] prevWake;
        logic [23:0] wakeEn;
        logic [3:0] wakeFilt;
        logic [4:0] selC;
        logic [4:0] selD;
        logic [3:0][2:0] cfgMode;
        logic [3:0] cfgFilt;
        logic [3:0] pending;
        logic [3:0] mask;
        logic waitReq;
        logic [31:0] rdata;
        logic irq;
        logic wakeEvent;
        logic bootDone;
    } gpw_state_type;

    gpw_state_type st;
    gpw_state_type next_st;

    logic [3:0] chanIn;
    logic [3:0] chanEvent;
    logic wr;

    // Reserved select codes read as a quiet low line
    function automatic logic pick_pin(input logic [23:0] v, input logic [4:0] s);
        logic r;
        r = 1'b0;
        if (s <= gpw_pkg::SEL_LAST_PIN)
            r = v[s];
        return r;
    endfunction

    // ****************************************
    // Trigger detectors
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_chan
            gpw_trig_detect u_det
            (
                .clk(clk),
                .resetn(resetn),
                .level(chanIn[g]),
                .mode(st.cfgMode[g]),
                .trigEvent(chanEvent[g])
            );
        end
    endgenerate

    assign wr = write & ~st.waitReq;

    // Interrupt inputs, raw or filtered per line
    // Kept apart from the next-state process so no loop runs through the detectors
    always_comb
    begin
        logic [23:0] pins;
        pins = st.cfgFilt[2] ? st.filt[23:0] : st.sync2[23:0];
        chanIn[0] = st.cfgFilt[0] ? st.filt[gpw_pkg::EXT_A_LINE]
                                  : st.sync2[gpw_pkg::EXT_A_LINE];
        chanIn[1] = st.cfgFilt[1] ? st.filt[gpw_pkg::EXT_B_LINE]
                                  : st.sync2[gpw_pkg::EXT_B_LINE];
        chanIn[2] = pick_pin(pins, st.selC);
        pins = st.cfgFilt[3] ? st.filt[23:0] : st.sync2[23:0];
        chanIn[3] = pick_pin(pins, st.selD);
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic [24:0] wakeLvl;
        logic [24:0] wakeMon;
        logic [3:0] clr;
        logic useFilt;
        logic selRawD;
        logic selFiltD;
        wakeLvl = '0;
        wakeMon = '0;
        clr = '0;
        useFilt = 1'b0;
        selRawD = 1'b0;
        selFiltD = 1'b0;
        next_st = st;
        next_st.bootDone = 1'b1;

        // Two flops per pin; only the second is ever read
        next_st.sync1 = {extIntB, extIntA, portC, portB, portA};
        next_st.sync2 = st.sync1;

        // Digital filter: a change passes after FILTER_CYCLES steady samples
        for (int i = 0; i < 26; i++)
        begin
            if (st.sync2[i] == st.filt[i])
                next_st.filtCnt[i] = '0;
            else if (st.filtCnt[i] == FILT_LAST)
            begin
                next_st.filt[i] = st.sync2[i];
                next_st.filtCnt[i] = '0;
            end
            else
                next_st.filtCnt[i] = st.filtCnt[i] + 1'b1;
        end

        // Wake sources; filtering chosen per source
        for (int i = 0; i < 24; i++)
        begin
            useFilt = st.wakeFilt[gpw_pkg::WFILT_PINS_BIT];
            if (i == gpw_pkg::SER1_WAKE_PIN && st.wakeFilt[gpw_pkg::WFILT_SER1_BIT])
                useFilt = 1'b1;
            if (i == gpw_pkg::SER2_WAKE_PIN && st.wakeFilt[gpw_pkg::WFILT_SER2_BIT])
                useFilt = 1'b1;
            wakeLvl[i] = useFilt ? st.filt[i] : st.sync2[i];
        end
        selRawD = pick_pin(st.sync2[23:0], st.selD);
        selFiltD = pick_pin(st.filt[23:0], st.selD);
        wakeLvl[24] = st.wakeFilt[gpw_pkg::WFILT_EXTD_BIT] ? selFiltD : selRawD;
        wakeMon = {st.cfgMode[3] != gpw_pkg::MODE_OFF, st.wakeEn};
        next_st.prevWake = wakeLvl;
        next_st.wakeEvent = |((wakeLvl ^ st.prevWake) & wakeMon);

        // Bus: one wait cycle, then the request is accepted
        next_st.waitReq = ~((read | write) & st.waitReq);
        if ((read | write) & st.waitReq)
        begin
            case (address)
                gpw_pkg::ADDR_PENDING: next_st.rdata = {28'h0, st.pending};
                gpw_pkg::ADDR_CFG_A: next_st.rdata = {23'h0, st.cfgFilt[0], st.cfgMode[0], 5'h0};
                gpw_pkg::ADDR_CFG_B: next_st.rdata = {23'h0, st.cfgFilt[1], st.cfgMode[1], 5'h0};
                gpw_pkg::ADDR_CFG_C: next_st.rdata = {23'h0, st.cfgFilt[2], st.cfgMode[2], 5'h0};
                gpw_pkg::ADDR_CFG_D: next_st.rdata = {23'h0, st.cfgFilt[3], st.cfgMode[3], 5'h0};
                gpw_pkg::ADDR_WAKE_A: next_st.rdata = {24'h0, st.wakeEn[7:0]};
                gpw_pkg::ADDR_WAKE_B: next_st.rdata = {24'h0, st.wakeEn[15:8]};
                gpw_pkg::ADDR_WAKE_C: next_st.rdata = {24'h0, st.wakeEn[23:16]};
                gpw_pkg::ADDR_SEL_C: next_st.rdata = {27'h0, st.selC};
                gpw_pkg::ADDR_SEL_D: next_st.rdata = {27'h0, st.selD};
                gpw_pkg::ADDR_WAKE_FILT: next_st.rdata = {28'h0, st.wakeFilt};
                gpw_pkg::ADDR_IRQ_MASK: next_st.rdata = {28'h0, st.mask};
                default: next_st.rdata = 32'h0;
            endcase
        end

        if (wr)
        begin
            case (address)
                gpw_pkg::ADDR_PENDING: clr = writedata[3:0];
                gpw_pkg::ADDR_CFG_A,
                gpw_pkg::ADDR_CFG_B,
                gpw_pkg::ADDR_CFG_C,
                gpw_pkg::ADDR_CFG_D:
                begin
                    next_st.cfgFilt[address[3:2]] = writedata[gpw_pkg::CFG_FILT_BIT];
                    next_st.cfgMode[address[3:2]] =
                        writedata[gpw_pkg::CFG_MODE_LSB +: 3];
                end
                gpw_pkg::ADDR_WAKE_A: next_st.wakeEn[7:0] = writedata[7:0];
                gpw_pkg::ADDR_WAKE_B: next_st.wakeEn[15:8] = writedata[7:0];
                gpw_pkg::ADDR_WAKE_C: next_st.wakeEn[23:16] = writedata[7:0];
                gpw_pkg::ADDR_SEL_C: next_st.selC = writedata[4:0];
                gpw_pkg::ADDR_SEL_D: next_st.selD = writedata[4:0];
                gpw_pkg::ADDR_WAKE_FILT: next_st.wakeFilt = writedata[3:0];
                gpw_pkg::ADDR_IRQ_MASK: next_st.mask = writedata[3:0];
                default: clr = '0;
            endcase
        end

        // A new event in the clearing cycle wins, so level modes refire
        next_st.pending = (st.pending & ~clr) | chanEvent;
        next_st.irq = |(next_st.pending & next_st.mask);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.selC <= gpw_pkg::SEL_C_RESET;
            st.selD <= gpw_pkg::SEL_D_RESET;
            st.waitReq <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign readdata = st.rdata;
    assign waitrequest = st.waitReq;
    assign irq = st.irq;
    assign wakeEvent = st.wakeEvent;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_clear_a;
        wr && address == gpw_pkg::ADDR_PENDING && writedata[0];
    endsequence

    sequence s_level_a_held;
        st.cfgMode[0] == gpw_pkg::MODE_HIGH && chanIn[0];
    endsequence

    a_sel_reset_vals: assert property (!st.bootDone |->
        st.selC == 5'h0f && st.selD == 5'h10)
        else $error("selector reset value wrong");

    a_sync_two_flops: assert property (st.bootDone && $past(st.bootDone) |->
        st.sync2[23:0] == $past({portC, portB, portA}, 2))
        else $error("pin sample not two cycles old");

    a_pend_sets: assert property (chanEvent[0] |=> st.pending[0])
        else $error("event did not set pending flag");

    a_pend_w1c: assert property (wr && address == gpw_pkg::ADDR_PENDING
        && writedata[2] && !chanEvent[2] |=> !st.pending[2])
        else $error("write one did not clear flag");

    a_pend_w0_keeps: assert property (wr && address == gpw_pkg::ADDR_PENDING
        && !writedata[0] && st.pending[0] |=> st.pending[0])
        else $error("write zero changed flag");

    a_level_refire: assert property (s_clear_a and s_level_a_held
        |=> st.pending[0])
        else $error("held level did not refire");

    a_rsvd_mode_quiet: assert property (st.cfgMode[0] >= 3'h6 |-> !chanEvent[0])
        else $error("reserved mode fired");

    a_wake_unmonitored: assert property (st.wakeEn == 24'h0
        && st.cfgMode[3] == gpw_pkg::MODE_OFF |=> !st.wakeEvent)
        else $error("wake without any monitored pin");

    a_filter_steady: assert property ($changed(st.filt[24]) |->
        $past(st.sync2[24]) == st.filt[24] && $past(st.sync2[24], 2) == st.filt[24])
        else $error("filter passed an unsteady input");

    a_irq_follows: assert property ((|(st.pending & st.mask)) |-> st.irq)
        else $error("interrupt low with unmasked flag");

    a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
endmodule

/* File: tb/gpw_pin_model.sv */
// Model of the external signals on the port pins and interrupt lines
`timescale 1ns/1ps
module gpw_pin_model
(
    // Clock
    input wire logic clk,
    // Levels asked for by the bench
    input wire logic [25:0] want,
    // Pins toward the block
    output logic [7:0] portA,
    output logic [7:0] portB,
    output logic [7:0] portC,
    output logic extIntA,
    output logic extIntB
);
    initial
    begin
        {extIntB, extIntA, portC, portB, portA} = 26'h0;
    end

    // Pins move a cycle late and unrelated to bus traffic, as a real source would
    always @(posedge clk)
    begin
        {extIntB, extIntA, portC, portB, portA} <= want;
    end
endmodule

/* File: tb/gpw_wake_irq_test.sv */
// Self-checking bench for the pin wakeup and external interrupt block
`timescale 1ns/1ps
module gpw_wake_irq_test;
    // Short filter keeps the glitch tests brief
    localparam int FILT = 2;
    logic clk;
    logic resetn;
    logic [31:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] portA;
    logic [7:0] portB;
    logic [7:0] portC;
    logic extIntA;
    logic extIntB;
    logic irq;
    logic wakeEvent;
    logic [25:0] pinWant;
    logic [31:0] expQ[$];
    logic [31:0] adrQ[$];
    logic [31:0] regAdr[12];
    logic [31:0] regRst[12];
    logic [31:0] regMsk[12];
    logic [31:0] d;
    integer seed;
    int miscompares;
    int n_checks;
    int wakeCnt;
    int w0;
    int code;
    int pinIdx[4];

    gpw_pin_model u_gpw_pin_model (.clk(clk), .want(pinWant), .portA(portA), .portB(portB),
        .portC(portC), .extIntA(extIntA), .extIntB(extIntB));
    gpw_wake_irq #(.FILTER_CYCLES(FILT)) u_gpw_wake_irq (.clk(clk), .resetn(resetn),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .portA(portA), .portB(portB),
        .portC(portC), .extIntA(extIntA), .extIntB(extIntB), .irq(irq), .wakeEvent(wakeEvent));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_cyc(input logic rd, input logic [31:0] a, input logic [31:0] wd);
        address <= a;
        writedata <= wd;
        read <= rd;
        write <= !rd;
        @(posedge clk);
        while (waitrequest !== 1'b0)
        begin
            @(posedge clk);
        end
        read <= 1'b0;
        write <= 1'b0;
        // Idle edge so a following request never lands in the same time step
        @(posedge clk);
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] wd);
        bus_cyc(1'b0, a, wd);
    endtask

    task automatic bus_rd(input logic [31:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        adrQ.push_back(a);
        bus_cyc(1'b1, a, 32'h0);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic glitch(input int p);
        pinWant[p] <= 1'b1;
        @(posedge clk);
        pinWant[p] <= 1'b0;
        waitc(12);
    endtask

    // Read data taken at the accept edge, oldest note first
    always @(posedge clk)
    begin
        if (read === 1'b1 && waitrequest === 1'b0 && expQ.size() > 0)
        begin
            check_word($sformatf("read %h", adrQ.pop_front()), expQ.pop_front(), readdata);
        end
        if (wakeEvent === 1'b1)
        begin
            wakeCnt++;
        end
    end

    initial
    begin
        #(40 * 20000);
        miscompares++;
        $display("watchdog expired");
        end_sim();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        seed = 32'hadcf;
        resetn = 1'b0;
        address = 32'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        pinWant = 26'h0;
        wakeCnt = 0;
        miscompares = 0;
        n_checks = 0;
        pinIdx = '{5, 10, 2, 16};
        regAdr = '{gpw_pkg::ADDR_CFG_A, gpw_pkg::ADDR_CFG_B, gpw_pkg::ADDR_CFG_C,
            gpw_pkg::ADDR_CFG_D, gpw_pkg::ADDR_WAKE_A, gpw_pkg::ADDR_WAKE_B,
            gpw_pkg::ADDR_WAKE_C, gpw_pkg::ADDR_SEL_C, gpw_pkg::ADDR_SEL_D,
            gpw_pkg::ADDR_WAKE_FILT, gpw_pkg::ADDR_IRQ_MASK, gpw_pkg::ADDR_PENDING};
        regRst = '{default: 32'h0};
        regRst[7] = 32'hf;
        regRst[8] = 32'h10;
        regMsk = '{32'h1e0, 32'h1e0, 32'h1e0, 32'h1e0, 32'hff, 32'hff, 32'hff, 32'h1f,
            32'h1f, 32'hf, 32'hf, 32'hf};
        waitc(6);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 12; i++)
        begin
            bus_rd(regAdr[i], regRst[i]);
        end
        bus_rd(32'h4000bc24, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 11; i++)
        begin
            d = $random(seed);
            bus_wr(regAdr[i], d);
            bus_rd(regAdr[i], d & regMsk[i]);
            bus_wr(regAdr[i], regRst[i]);
        end
        bus_wr(gpw_pkg::ADDR_PENDING, 32'hf);
        bus_rd(gpw_pkg::ADDR_PENDING, 32'h0);
        $display("test register access done");
        // Every trigger code on interrupt A, reserved ones included
        for (int m = 0; m < 8; m++)
        begin
            pinWant[24] <= 1'b0;
            waitc(6);
            bus_wr(gpw_pkg::ADDR_CFG_A, {23'h0, 1'b0, 3'(m), 5'h0});
            waitc(6);
            bus_wr(gpw_pkg::ADDR_PENDING, 32'h1);
            bus_rd(gpw_pkg::ADDR_PENDING, {31'h0, m == 5});
            pinWant[24] <= 1'b1;
            waitc(8);
            bus_wr(gpw_pkg::ADDR_PENDING, 32'h0);
            bus_rd(gpw_pkg::ADDR_PENDING, {31'h0, m == 1 || m == 3 || m == 4 || m == 5});
            bus_wr(gpw_pkg::ADDR_PENDING, 32'h1);
            pinWant[24] <= 1'b0;
            waitc(8);
            bus_rd(gpw_pkg::ADDR_PENDING, {31'h0, m > 1 && m < 6});
        end
        bus_wr(gpw_pkg::ADDR_CFG_A, 32'h0);
        $display("test trigger modes done");
        bus_wr(gpw_pkg::ADDR_CFG_C, 32'h20);
        bus_wr(gpw_pkg::ADDR_IRQ_MASK, 32'h4);
        for (int i = 0; i < 4; i++)
        begin
            code = {$random(seed)} % 24;
            bus_wr(gpw_pkg::ADDR_SEL_C, 32'(code));
            bus_wr(gpw_pkg::ADDR_PENDING, 32'hf);
            pinWant[code] <= 1'b1;
            waitc(8);
            bus_rd(gpw_pkg::ADDR_PENDING, 32'h4);
            check_word("irq raised", 32'h1, {31'h0, irq});
            pinWant[code] <= 1'b0;
            waitc(4);
        end
        bus_wr(gpw_pkg::ADDR_IRQ_MASK, 32'h0);
        waitc(2);
        check_word("irq masked", 32'h0, {31'h0, irq});
        bus_wr(gpw_pkg::ADDR_IRQ_MASK, 32'h4);
        waitc(2);
        check_word("irq unmasked", 32'h1, {31'h0, irq});
        bus_wr(gpw_pkg::ADDR_PENDING, 32'h4);
        waitc(2);
        check_word("irq cleared", 32'h0, {31'h0, irq});
        bus_wr(gpw_pkg::ADDR_SEL_C, 32'h18);
        pinWant[23:0] <= 24'hffffff;
        waitc(8);
        bus_rd(gpw_pkg::ADDR_PENDING, 32'h0);
        pinWant[23:0] <= 24'h0;
        waitc(8);
        bus_wr(gpw_pkg::ADDR_CFG_C, 32'h0);
        bus_wr(gpw_pkg::ADDR_IRQ_MASK, 32'h0);
        $display("test selector and irq done");
        bus_wr(gpw_pkg::ADDR_CFG_A, 32'h120);
        glitch(24);
        bus_rd(gpw_pkg::ADDR_PENDING, 32'h0);
        pinWant[24] <= 1'b1;
        waitc(12);
        bus_rd(gpw_pkg::ADDR_PENDING, 32'h1);
        pinWant[24] <= 1'b0;
        bus_wr(gpw_pkg::ADDR_CFG_A, 32'h0);
        $display("test input filter done");
        bus_wr(gpw_pkg::ADDR_WAKE_A, 32'h24);
        bus_wr(gpw_pkg::ADDR_WAKE_B, 32'h04);
        bus_wr(gpw_pkg::ADDR_CFG_D, 32'h20);
        for (int i = 0; i < 4; i++)
        begin
            bus_wr(gpw_pkg::ADDR_WAKE_FILT, 32'h1 << i);
            w0 = wakeCnt;
            glitch(pinIdx[i]);
            check_word("wake filtered", 32'h0, 32'(wakeCnt - w0));
            bus_wr(gpw_pkg::ADDR_WAKE_FILT, 32'h0);
            w0 = wakeCnt;
            glitch(pinIdx[i]);
            check_word("wake raw", 32'h2, 32'(wakeCnt - w0));
        end
        w0 = wakeCnt;
        glitch(3);
        check_word("wake unmonitored", 32'h0, 32'(wakeCnt - w0));
        // Interrupt D rose on port C pin 0 above; A still holds its filtered rise
        bus_rd(gpw_pkg::ADDR_PENDING, 32'h9);
        bus_wr(gpw_pkg::ADDR_PENDING, 32'hf);
        bus_wr(gpw_pkg::ADDR_CFG_B, 32'h60);
        glitch(25);
        bus_rd(gpw_pkg::ADDR_PENDING, 32'h2);
        bus_wr(gpw_pkg::ADDR_CFG_B, 32'h0);
        $display("test wake sources done");
        end_sim();
    end
endmodule
